// ---- common/dcm_params.svh ----
// parameter numbers, field positions and reset values of the drive control block
`ifndef DCM_PARAMS_SVH
`define DCM_PARAMS_SVH
// parameter numbers on the parameter access port
`define DCM_PAR_CTRL_WORD 11'd410
`define DCM_PAR_STATUS_WORD 11'd411
`define DCM_PAR_CTRL_SOURCE 11'd412
`define DCM_PAR_DS_SELECT 11'd414
`define DCM_PAR_ACTIVE_DS 11'd249
`define DCM_PAR_DIG_INPUTS 11'd250
`define DCM_PAR_WARNINGS 11'd270
`define DCM_PAR_CTRL_STATUS 11'd275
`define DCM_PAR_HYSTERESIS 11'd549
`define DCM_PAR_FAULT_REACT 11'd1143
`define DCM_PAR_INIT_POS 11'd1185
`define DCM_PAR_HOMING_MODE 11'd1130
// reset values and limits
`define DCM_SRC_RESET 16'h002C
`define DCM_SRC_MAX 16'h002C
`define DCM_DS_SEL_RESET 16'h0000
`define DCM_DS_SEL_MAX 16'h0005
`define DCM_DS_SEL_LOCKED 16'h0005
`define DCM_INIT_POS_HOLD 16'hFFFF
`define DCM_HYST_RESET 16'h0000
// status word bit positions
`define DCM_SW_VOLTAGE 4
`define DCM_SW_WARNING 7
`define DCM_SW_REMOTE 9
`define DCM_SW_TARGET 10
`define DCM_SW_LIMIT 11
`define DCM_SW_WARNING2 15
// control word bit positions
`define DCM_CW_SWITCH_ON 0
`define DCM_CW_FAULT_RESET 7
`define DCM_CW_VIRT_CW 11
`define DCM_CW_VIRT_CCW 12
`define DCM_CW_HOME_START 13
// homing mode field positions
`define DCM_HM_DIR_POS 0
`define DCM_HM_REVERSE 1
`endif

// ---- common/dcm_pkg.sv ----
// types shared by the drive control block
package dcm_pkg;
  typedef enum logic [1:0] {
    DCM_SRC_CONTACTS = 2'h0,
    DCM_SRC_STATE_MACHINE = 2'h1,
    DCM_SRC_REMOTE_CONTACTS = 2'h2,
    DCM_SRC_PANEL = 2'h3
  } dcm_src_t;
  typedef enum logic [3:0] {
    DCM_HS_IDLE = 4'h1,
    DCM_HS_SEARCH = 4'h2,
    DCM_HS_GOTO = 4'h4,
    DCM_HS_DONE = 4'h8
  } dcm_home_state_t;
endpackage

// ---- common/dcm_home_if.sv ----
// carrier between the top level and the homing sequencer
`timescale 1ns/1ns
interface dcm_home_if;
  logic start;
  logic dir_pos;
  logic reverse_en;
  logic hold_at_stop;
  logic home_sw;
  logic lim_pos;
  logic lim_neg;
  logic at_target;
  logic move_pos;
  logic move_neg;
  logic goto_pos;
  logic busy;
  logic homed;
  modport ctl (
    output start, dir_pos, reverse_en, hold_at_stop, home_sw, lim_pos, lim_neg, at_target,
    input move_pos, move_neg, goto_pos, busy, homed
  );
  modport hom (
    input start, dir_pos, reverse_en, hold_at_stop, home_sw, lim_pos, lim_neg, at_target,
    output move_pos, move_neg, goto_pos, busy, homed
  );
endinterface

// ---- hw/dcm_sync.sv ----
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
module dcm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_reg <= '0;
      sync_o <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule // dcm_sync

// ---- hw/dcm_homing.sv ----
// homing sequencer: search, optional reversal at a limit, then hold or move to start
`timescale 1ns/1ns
`include "dcm_params.svh"
module dcm_homing
  import dcm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  dcm_home_if.hom hif
);
  dcm_home_state_t state_reg, state_next;
  logic dir_reg, dir_next;
  logic homed_reg;
  wire hit_limit = dir_reg ? hif.lim_pos : hif.lim_neg;
  wire stop_here = hif.home_sw | (hit_limit & ~hif.reverse_en);
  // next state of the search
  always_comb begin
    state_next = state_reg;
    dir_next = dir_reg;
    case (state_reg)
      DCM_HS_IDLE, DCM_HS_DONE: begin
        if (hif.start) begin
          state_next = DCM_HS_SEARCH;
          dir_next = hif.dir_pos;
        end
      end
      DCM_HS_SEARCH: begin
        if (stop_here) begin
          state_next = hif.hold_at_stop ? DCM_HS_DONE : DCM_HS_GOTO;
        end else if (hit_limit) begin
          dir_next = ~dir_reg;
        end
      end
      DCM_HS_GOTO: begin
        if (hif.at_target) begin
          state_next = DCM_HS_DONE;
        end
      end
      default: begin
        state_next = DCM_HS_IDLE;
      end
    endcase
  end
  // state, direction and the homed flag
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= DCM_HS_IDLE;
      dir_reg <= 1'b0;
      homed_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      dir_reg <= dir_next;
      homed_reg <= (state_next == DCM_HS_DONE);
    end
  end
  // a new start drops the reference until the sequencer reaches done again
  assign hif.move_pos = (state_reg == DCM_HS_SEARCH) & dir_reg;
  assign hif.move_neg = (state_reg == DCM_HS_SEARCH) & ~dir_reg;
  assign hif.goto_pos = (state_reg == DCM_HS_GOTO);
  assign hif.busy = (state_reg == DCM_HS_SEARCH) | (state_reg == DCM_HS_GOTO);
  assign hif.homed = homed_reg;
endmodule // dcm_homing

// ---- hw/dcm_drive_ctl.sv ----
// drive control source, data sets, homing, limit lockout and status word
// Overview of operation
// - homing searches then stops at a switch
// - reverse at limit if mode asks and fault reaction is 0
// - homing starts from input, bus, auto
// - initial position -1 holds, else moves
// - only absolute moves need homing first
// - limit trip raises error, blocks direction
// - reset clears error only with both switches released
// - limit warning follows switch level
// - source selector 0..44, default 44
// - 0 uses pins, 2 uses control word
// - source selector stored per data set
// - selection 0 contacts, 1..4 forced
// - selection 5 contacts only while disabled
// - active data set readable as 1..4
// - enable input one needs both releases
// - status bit 4 shows mains present
// - status bit 7 flags any warning
// - status bit 10 target reached
// - status bit 11 internal limit active
// - status bit 15 imminent fault warning
`timescale 1ns/1ns
`include "dcm_params.svh"
module dcm_drive_ctl
  import dcm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // parameter access port
  input wire logic par_wr_i,
  input wire logic par_rd_i,
  input wire logic [10:0] par_num_i,
  input wire logic [15:0] par_wdata_i,
  output logic [15:0] par_rdata_o,
  output logic par_ack_o,
  output logic par_err_o,
  // pins
  input wire logic torque_release_a_i,
  input wire logic torque_release_b_i,
  input wire logic start_cw_i,
  input wire logic start_ccw_i,
  input wire logic [1:0] ds_contacts_i,
  input wire logic limit_pos_i,
  input wire logic limit_neg_i,
  input wire logic home_switch_i,
  input wire logic home_start_in_i,
  input wire logic mains_ok_i,
  // internal drive logic
  input wire logic vel_pos_req_i,
  input wire logic vel_neg_req_i,
  input wire logic rel_pos_req_i,
  input wire logic abs_pos_req_i,
  input wire logic target_dir_pos_i,
  input wire logic at_target_i,
  input wire logic [15:0] reference_i,
  input wire logic [15:0] actual_i,
  input wire logic pf_zero_hz_i,
  input wire logic current_limit_i,
  input wire logic torque_limit_i,
  input wire logic overvolt_ctl_i,
  input wire logic [3:0] delayed_warn_i,
  input wire logic [11:0] warn_code_i,
  // drive commands and state
  output logic run_pos_o,
  output logic run_neg_o,
  output logic abs_start_o,
  output logic goto_init_o,
  output logic homed_o,
  output logic limit_error_o,
  output logic [15:0] status_word_o,
  output logic [2:0] active_ds_o
);
  // synchronised pins
  logic [10:0] pin_sync;
  logic sta, stb, cw_pin, ccw_pin, lim_p, lim_n, home_sw, home_di, mains;
  logic [1:0] ds_pin;
  dcm_sync #(.WIDTH(11)) u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i({torque_release_a_i, torque_release_b_i, start_cw_i, start_ccw_i,
              ds_contacts_i, limit_pos_i, limit_neg_i, home_switch_i,
              home_start_in_i, mains_ok_i}),
    .sync_o(pin_sync)
  );
  assign {sta, stb, cw_pin, ccw_pin, ds_pin, lim_p, lim_n, home_sw, home_di, mains} = pin_sync;

  // writable parameters and the data set index
  logic [15:0] ctrl_word_reg;
  logic [15:0] src_reg [4];
  logic [15:0] ds_sel_reg;
  logic [15:0] hyst_reg;
  logic [15:0] fault_react_reg;
  logic [15:0] init_pos_reg;
  logic [15:0] home_mode_reg;
  logic [1:0] ds_idx_reg;
  logic [1:0] ds_idx_next;

  wire wr_cw = par_wr_i & (par_num_i == `DCM_PAR_CTRL_WORD);
  wire wr_src = par_wr_i & (par_num_i == `DCM_PAR_CTRL_SOURCE);
  wire wr_dss = par_wr_i & (par_num_i == `DCM_PAR_DS_SELECT);
  wire wr_hys = par_wr_i & (par_num_i == `DCM_PAR_HYSTERESIS);
  wire wr_frc = par_wr_i & (par_num_i == `DCM_PAR_FAULT_REACT);
  wire wr_ini = par_wr_i & (par_num_i == `DCM_PAR_INIT_POS);
  wire wr_hmd = par_wr_i & (par_num_i == `DCM_PAR_HOMING_MODE);
  wire src_bad = wr_src & (par_wdata_i > `DCM_SRC_MAX);
  wire dss_bad = wr_dss & (par_wdata_i > `DCM_DS_SEL_MAX);

  // control word and plain settings
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_word_reg <= 16'h0000;
      ds_sel_reg <= `DCM_DS_SEL_RESET;
      hyst_reg <= `DCM_HYST_RESET;
      fault_react_reg <= 16'h0001;
      init_pos_reg <= `DCM_INIT_POS_HOLD;
      home_mode_reg <= 16'h0000;
    end else begin
      if (wr_cw) ctrl_word_reg <= par_wdata_i;
      if (wr_dss && !dss_bad) ds_sel_reg <= par_wdata_i;
      if (wr_hys) hyst_reg <= par_wdata_i;
      if (wr_frc) fault_react_reg <= par_wdata_i;
      if (wr_ini) init_pos_reg <= par_wdata_i;
      if (wr_hmd) home_mode_reg <= par_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 4; i++) src_reg[i] <= `DCM_SRC_RESET;
    end else if (wr_src && !src_bad) begin
      src_reg[ds_idx_reg] <= par_wdata_i;
    end
  end

  // decoded control source of the active data set
  wire [15:0] src_val = src_reg[ds_idx_reg];
  wire src_contacts = (src_val == 16'h0000);
  wire src_sm = (src_val == 16'h0001);
  wire src_remote = (src_val == 16'h0002);
  dcm_src_t src_mode;
  assign src_mode = src_contacts ? DCM_SRC_CONTACTS :
                    src_sm ? DCM_SRC_STATE_MACHINE :
                    src_remote ? DCM_SRC_REMOTE_CONTACTS : DCM_SRC_PANEL;

  // drive enable: both releases plus switch-on bit
  logic run_pos_reg, run_neg_reg;
  wire enable_input_one = sta & stb & ctrl_word_reg[`DCM_CW_SWITCH_ON];
  wire drive_enabled = run_pos_reg | run_neg_reg;

  wire ds_forced = (ds_sel_reg >= 16'h0001) & (ds_sel_reg <= 16'h0004);
  wire ds_locked = (ds_sel_reg == `DCM_DS_SEL_LOCKED);
  assign ds_idx_next = ds_forced ? ds_sel_reg[1:0] - 2'h1 :
                       (ds_locked && drive_enabled) ? ds_idx_reg : ds_pin;

  // limit trip: direction lock held while switch active or error not reset
  logic lock_pos_reg, lock_neg_reg, err_reg, fr_prev_reg;
  wire fault_reset = ctrl_word_reg[`DCM_CW_FAULT_RESET] & ~fr_prev_reg;
  wire err_on = fault_react_reg != 16'h0000;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_pos_reg <= 1'b0;
      lock_neg_reg <= 1'b0;
      err_reg <= 1'b0;
      fr_prev_reg <= 1'b0;
    end else begin
      fr_prev_reg <= ctrl_word_reg[`DCM_CW_FAULT_RESET];
      // reset frees released side only; set wins
      lock_pos_reg <= lim_p | (lock_pos_reg & ~fault_reset);
      lock_neg_reg <= lim_n | (lock_neg_reg & ~fault_reset);
      err_reg <= (err_on & (lim_p | lim_n)) | (err_reg & ~fault_reset);
    end
  end

  // homing sequencer
  dcm_home_if hif ();
  logic abs_pending_reg;
  // input, bus bit, or automatic start
  wire home_bus = src_sm & ctrl_word_reg[`DCM_CW_HOME_START];
  wire auto_home = src_sm & abs_pos_req_i & ~hif.homed & ~hif.busy & ~abs_pending_reg;
  assign hif.start = ~hif.busy & (home_di | home_bus | auto_home);
  assign hif.dir_pos = home_mode_reg[`DCM_HM_DIR_POS];
  assign hif.reverse_en = home_mode_reg[`DCM_HM_REVERSE];
  assign hif.hold_at_stop = (init_pos_reg == `DCM_INIT_POS_HOLD);
  assign hif.home_sw = home_sw;
  assign hif.lim_pos = lim_p;
  assign hif.lim_neg = lim_n;
  assign hif.at_target = at_target_i;
  dcm_homing u_homing (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .hif(hif)
  );

  // requested direction by control source
  wire cw_virt = ctrl_word_reg[`DCM_CW_VIRT_CW];
  wire ccw_virt = ctrl_word_reg[`DCM_CW_VIRT_CCW];
  wire sm_pos_move = src_sm & (rel_pos_req_i | (abs_pos_req_i & hif.homed));
  wire want_pos = hif.busy ? hif.move_pos :
                  src_contacts ? cw_pin :
                  src_remote ? cw_virt :
                  src_sm ? (vel_pos_req_i | (sm_pos_move & target_dir_pos_i)) : 1'b0;
  wire want_neg = hif.busy ? hif.move_neg :
                  src_contacts ? ccw_pin :
                  src_remote ? ccw_virt :
                  src_sm ? (vel_neg_req_i | (sm_pos_move & ~target_dir_pos_i)) : 1'b0;
  // homing search may run into the limit it is looking for; error blocks all moves, homing included
  wire free_run = enable_input_one & ~err_reg;
  wire run_pos_next = free_run & want_pos & ~want_neg & (~lock_pos_reg | hif.busy);
  wire run_neg_next = free_run & want_neg & ~want_pos & (~lock_neg_reg | hif.busy);

  // status word sources
  wire [16:0] diff = {reference_i[15], reference_i} - {actual_i[15], actual_i};
  wire [16:0] diff_abs = diff[16] ? (17'h00000 - diff) : diff;
  wire in_hyst = diff_abs <= {1'b0, hyst_reg};
  wire limit_warn = lim_p | lim_n;
  logic [15:0] sw_next;
  always_comb begin
    sw_next = 16'h0000;
    sw_next[`DCM_SW_VOLTAGE] = mains;
    sw_next[`DCM_SW_WARNING] = (|warn_code_i) | limit_warn | (|delayed_warn_i);
    sw_next[`DCM_SW_REMOTE] = src_sm;
    // target reached or zero after power failure
    sw_next[`DCM_SW_TARGET] = in_hyst | pf_zero_hz_i;
    sw_next[`DCM_SW_LIMIT] = current_limit_i | torque_limit_i | overvolt_ctl_i;
    sw_next[`DCM_SW_WARNING2] = |delayed_warn_i;
  end

  // readouts
  wire [15:0] warn_word = {limit_warn, delayed_warn_i != 4'h0, lim_n, lim_p, warn_code_i};
  wire [15:0] ctl_stat = {12'h000, err_reg, lock_neg_reg, lock_pos_reg, hif.homed};
  wire [15:0] dig_word = {10'h000, ds_pin, ccw_virt | ccw_pin, cw_virt | cw_pin,
                          enable_input_one, mains};
  logic [15:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (par_num_i)
      `DCM_PAR_CTRL_WORD: rd_mux = ctrl_word_reg;
      `DCM_PAR_STATUS_WORD: rd_mux = status_word_o;
      `DCM_PAR_CTRL_SOURCE: rd_mux = src_val;
      `DCM_PAR_DS_SELECT: rd_mux = ds_sel_reg;
      `DCM_PAR_ACTIVE_DS: rd_mux = {13'h0000, active_ds_o};
      `DCM_PAR_DIG_INPUTS: rd_mux = dig_word;
      `DCM_PAR_WARNINGS: rd_mux = warn_word;
      `DCM_PAR_CTRL_STATUS: rd_mux = ctl_stat;
      `DCM_PAR_HYSTERESIS: rd_mux = hyst_reg;
      `DCM_PAR_FAULT_REACT: rd_mux = fault_react_reg;
      `DCM_PAR_INIT_POS: rd_mux = init_pos_reg;
      `DCM_PAR_HOMING_MODE: rd_mux = home_mode_reg;
      default: begin
        rd_mux = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end
  // writes to readouts or unknown numbers are refused
  wire ro_num = (par_num_i == `DCM_PAR_STATUS_WORD) | (par_num_i == `DCM_PAR_ACTIVE_DS) |
                (par_num_i == `DCM_PAR_DIG_INPUTS) | (par_num_i == `DCM_PAR_WARNINGS) |
                (par_num_i == `DCM_PAR_CTRL_STATUS);
  wire acc_err = ~rd_hit | (par_wr_i & ro_num) | src_bad | dss_bad;

  // registered outputs
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ds_idx_reg <= 2'h0;
      active_ds_o <= 3'h1;
      status_word_o <= 16'h0000;
      run_pos_reg <= 1'b0;
      run_neg_reg <= 1'b0;
      abs_pending_reg <= 1'b0;
      par_rdata_o <= 16'h0000;
      par_ack_o <= 1'b0;
      par_err_o <= 1'b0;
    end else begin
      ds_idx_reg <= ds_idx_next;
      active_ds_o <= {1'b0, ds_idx_next} + 3'h1;
      status_word_o <= sw_next;
      run_pos_reg <= run_pos_next;
      run_neg_reg <= run_neg_next;
      abs_pending_reg <= abs_pos_req_i & (abs_pending_reg | auto_home);
      par_rdata_o <= par_rd_i ? rd_mux : 16'h0000;
      par_ack_o <= par_rd_i | par_wr_i;
      par_err_o <= (par_rd_i | par_wr_i) & acc_err;
    end
  end

  // drive commands
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      abs_start_o <= 1'b0;
      goto_init_o <= 1'b0;
      homed_o <= 1'b0;
      limit_error_o <= 1'b0;
    end else begin
      abs_start_o <= src_sm & abs_pos_req_i & hif.homed & free_run;
      goto_init_o <= hif.goto_pos;
      homed_o <= hif.homed;
      limit_error_o <= err_reg;
    end
  end
  assign run_pos_o = run_pos_reg;
  assign run_neg_o = run_neg_reg;
endmodule // dcm_drive_ctl

// ---- tb/dcm_drive_ctl_properties.sv ----
// concurrent property checker for the drive control top, with its bind
`timescale 1ns/1ns
module dcm_drive_ctl_props (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic par_ack_o,
  input wire logic par_err_o,
  input wire logic torque_release_a_i,
  input wire logic limit_pos_i,
  input wire logic mains_ok_i,
  input wire logic pf_zero_hz_i,
  input wire logic current_limit_i,
  input wire logic torque_limit_i,
  input wire logic overvolt_ctl_i,
  input wire logic [3:0] delayed_warn_i,
  input wire logic [11:0] warn_code_i,
  input wire logic run_pos_o,
  input wire logic run_neg_o,
  input wire logic homed_o,
  input wire logic limit_error_o,
  input wire logic [15:0] status_word_o,
  input wire logic [2:0] active_ds_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // pins cross a two-stage sync, so a level held four edges must show
  mains_on_a: assert property (mains_ok_i [*4] |-> status_word_o[4])
    else $error("mains bit low with mains present");
  mains_off_a: assert property ((!mains_ok_i) [*4] |-> !status_word_o[4])
    else $error("mains bit high without mains");
  warn_bit_a: assert property ((|warn_code_i) |=> status_word_o[7])
    else $error("warning bit missing");
  target_pf_a: assert property (pf_zero_hz_i |=> status_word_o[10])
    else $error("target bit missing at zero frequency");
  int_limit_a: assert property (1 |=> status_word_o[11] ===
    $past(current_limit_i | torque_limit_i | overvolt_ctl_i))
    else $error("internal limit bit wrong");
  warn_two_a: assert property (1 |=> status_word_o[15] === (|$past(delayed_warn_i)))
    else $error("warning 2 bit wrong");
  ds_range_a: assert property (active_ds_o >= 3'h1 && active_ds_o <= 3'h4)
    else $error("active data set out of range");
  release_gate_a: assert property ((!torque_release_a_i) [*4] |-> !(run_pos_o | run_neg_o))
    else $error("run without torque release");
  limit_warn_a: assert property (limit_pos_i [*4] |-> status_word_o[7])
    else $error("limit warning missing");
  err_ack_a: assert property (par_err_o |-> par_ack_o)
    else $error("error without acknowledge");
  run_c: cover property ($rose(run_pos_o));
  homed_c: cover property ($rose(homed_o));
  trip_c: cover property ($rose(limit_error_o));
endmodule // dcm_drive_ctl_props

bind dcm_drive_ctl dcm_drive_ctl_props chk (.*);

// ---- tb/dcm_plc_model.sv ----
// field-bus master model issuing single parameter reads and writes
`timescale 1ns/1ns
module dcm_plc_model (
  input wire logic clk_sys_i,
  input wire logic ack_i,
  input wire logic err_i,
  input wire logic [15:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [10:0] num_o,
  output logic [15:0] wdata_o
);
  // idle at time zero
  initial begin
    {wr_o, rd_o, num_o, wdata_o} = '0;
  end
  // one-cycle request; idle lines then show the inverse so stale data never matches
  task automatic xfer(input logic w, input logic [10:0] n, input logic [15:0] d,
                      output logic [15:0] q, output logic e);
    @(posedge clk_sys_i);
    #1;
    {wr_o, rd_o, num_o, wdata_o} = {w, !w, n, d};
    @(posedge clk_sys_i);
    #1;
    {wr_o, rd_o, num_o, wdata_o} = {2'b00, ~n, ~d};
    q = ack_i ? rdata_i : 16'hXXXX;
    e = ack_i ? err_i : 1'bx;
  endtask
endmodule // dcm_plc_model

// ---- tb/test_drive_control_mode_status.sv ----
// random and directed bench for the drive control block
`timescale 1ns/1ns
`include "dcm_params.svh"
module test_drive_control_mode_status;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, torque_release_a_i = 1'b0, torque_release_b_i = 1'b0;
  logic start_cw_i = 1'b0, start_ccw_i = 1'b0, limit_pos_i = 1'b0, limit_neg_i = 1'b0;
  logic home_switch_i = 1'b0, home_start_in_i = 1'b0, mains_ok_i = 1'b0, pf_zero_hz_i = 1'b0;
  logic vel_pos_req_i = 1'b0, vel_neg_req_i = 1'b0, rel_pos_req_i = 1'b0, abs_pos_req_i = 1'b0;
  logic target_dir_pos_i = 1'b0, at_target_i = 1'b0, current_limit_i = 1'b0;
  logic torque_limit_i = 1'b0, overvolt_ctl_i = 1'b0;
  logic [1:0] ds_contacts_i = 2'h0;
  logic [3:0] delayed_warn_i = 4'h0;
  logic [11:0] warn_code_i = 12'h000;
  logic [15:0] reference_i = 16'h0000, actual_i = 16'h0000;
  logic par_wr_i, par_rd_i, par_ack_o, par_err_o, run_pos_o, run_neg_o, abs_start_o;
  logic goto_init_o, homed_o, limit_error_o, erf;
  logic [10:0] par_num_i;
  logic [15:0] par_wdata_i, par_rdata_o, status_word_o, rdat;
  logic [2:0] active_ds_o;
  logic [31:0] r;
  int seed = 32'hA957E98E;
  int fails = 0, cmp_count = 0;

  // every port of the block has a bench signal of its own name
  dcm_drive_ctl uut (.*);
  dcm_plc_model plc (
    .clk_sys_i(clk_sys_i), .ack_i(par_ack_o), .err_i(par_err_o), .rdata_i(par_rdata_o),
    .wr_o(par_wr_i), .rd_o(par_rd_i), .num_o(par_num_i), .wdata_o(par_wdata_i));

  // 25 MHz clock
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // watchdog, roughly thirty-four times the expected run
  initial begin
    #400000;
    fails++;
    end_of_test();
  end

  task automatic end_of_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // inputs always move 1 ns after an edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [10:0] n, input logic [15:0] d, input logic e);
    plc.xfer(1'b1, n, d, rdat, erf);
    chk(erf === e, "write response");
  endtask
  task automatic rdc(input logic [10:0] n, input logic [15:0] e, input logic [15:0] m);
    plc.xfer(1'b0, n, 16'h0000, rdat, erf);
    chk((rdat & m) === e && erf === 1'b0, "read value");
  endtask
  // expected status bits; the source bit 9 is masked by the caller
  function automatic logic [15:0] sw_exp(input logic [15:0] h);
    int dv;
    dv = $signed(reference_i) - $signed(actual_i);
    dv = (dv < 0) ? -dv : dv;
    sw_exp = 16'h0000;
    sw_exp[4] = mains_ok_i;
    sw_exp[7] = (|warn_code_i) | (|delayed_warn_i);
    sw_exp[10] = pf_zero_hz_i | (dv <= int'(h));
    sw_exp[11] = current_limit_i | torque_limit_i | overvolt_ctl_i;
    sw_exp[15] = |delayed_warn_i;
  endfunction

  // main sequence
  initial begin
    wt(2);
    reset_n_i = 1'b1;
    rdc(`DCM_PAR_CTRL_SOURCE, 16'h002C, 16'hFFFF);
    rdc(`DCM_PAR_DS_SELECT, 16'h0000, 16'hFFFF);
    rdc(`DCM_PAR_ACTIVE_DS, 16'h0001, 16'hFFFF);
    wr(`DCM_PAR_CTRL_SOURCE, 16'h002D, 1'b1);
    wr(`DCM_PAR_STATUS_WORD, 16'h0000, 1'b1);
    wr(`DCM_PAR_DS_SELECT, 16'h0006, 1'b1);
    wr(11'h7FF, 16'h0000, 1'b1);
    // forced sets get sources 0..3 so each set has its own selector
    for (int k = 1; k <= 4; k++) begin
      wr(`DCM_PAR_DS_SELECT, 16'(k), 1'b0);
      wt(2);
      chk(active_ds_o === 3'(k), "forced data set");
      wr(`DCM_PAR_CTRL_SOURCE, 16'(k - 1), 1'b0);
    end
    wr(`DCM_PAR_DS_SELECT, 16'h0000, 1'b0);
    for (int c = 0; c < 4; c++) begin
      ds_contacts_i = 2'(c);
      wt(4);
      rdc(`DCM_PAR_ACTIVE_DS, 16'(c + 1), 16'hFFFF);
      rdc(`DCM_PAR_CTRL_SOURCE, 16'(c), 16'hFFFF);
    end
    // remote contacts: virtual bits in the control word
    {torque_release_a_i, torque_release_b_i, mains_ok_i} = 3'b111;
    wr(`DCM_PAR_DS_SELECT, 16'h0003, 1'b0);
    wr(`DCM_PAR_CTRL_WORD, 16'h0801, 1'b0);
    wt(4);
    chk(run_pos_o === 1'b1 && run_neg_o === 1'b0, "virtual cw run");
    rdc(`DCM_PAR_DIG_INPUTS, 16'h0002, 16'h0002);
    torque_release_b_i = 1'b0;
    wt(4);
    chk(run_pos_o === 1'b0, "run with one release");
    rdc(`DCM_PAR_DIG_INPUTS, 16'h0000, 16'h0002);
    torque_release_b_i = 1'b1;
    wr(`DCM_PAR_CTRL_WORD, 16'h1001, 1'b0);
    wt(4);
    chk(run_neg_o === 1'b1 && run_pos_o === 1'b0, "virtual ccw run");
    // contacts source ignores the virtual bits
    wr(`DCM_PAR_DS_SELECT, 16'h0001, 1'b0);
    start_cw_i = 1'b1;
    wt(4);
    chk(run_pos_o === 1'b1 && run_neg_o === 1'b0, "pin cw run");
    start_cw_i = 1'b0;
    wr(`DCM_PAR_DS_SELECT, 16'h0002, 1'b0);
    vel_neg_req_i = 1'b1;
    wt(4);
    chk(run_neg_o === 1'b1 && status_word_o[9] === 1'b1, "state machine run");
    vel_neg_req_i = 1'b0;
    // panel source drives nothing from the bus side
    wr(`DCM_PAR_DS_SELECT, 16'h0004, 1'b0);
    {start_cw_i, vel_pos_req_i} = 2'b11;
    wt(4);
    chk(run_pos_o === 1'b0 && run_neg_o === 1'b0, "panel source idle");
    {start_cw_i, vel_pos_req_i} = 2'b00;
    // selection 5: contacts are frozen while running
    ds_contacts_i = 2'h1;
    wr(`DCM_PAR_DS_SELECT, 16'h0005, 1'b0);
    vel_pos_req_i = 1'b1;
    wt(4);
    ds_contacts_i = 2'h0;
    wt(4);
    chk(active_ds_o === 3'h2 && run_pos_o === 1'b1, "set held while running");
    vel_pos_req_i = 1'b0;
    wt(4);
    chk(active_ds_o === 3'h1, "set follows contacts");
    // random status inputs, hysteresis boundary first
    wr(`DCM_PAR_DS_SELECT, 16'h0002, 1'b0);
    wr(`DCM_PAR_HYSTERESIS, 16'h0004, 1'b0);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      {mains_ok_i, pf_zero_hz_i, current_limit_i, torque_limit_i, overvolt_ctl_i} = r[4:0];
      delayed_warn_i = r[9] ? r[13:10] : 4'h0;
      warn_code_i = r[14] ? r[31:20] : 12'h000;
      reference_i = {{4{r[15]}}, r[31:20]};
      actual_i = reference_i + ((i == 0) ? 16'h0004 : {{12{r[19]}}, r[19:16]});
      wt(4);
      chk((status_word_o & 16'hFDFF) === sw_exp(16'h0004), "status word");
    end
    {pf_zero_hz_i, current_limit_i, torque_limit_i, overvolt_ctl_i} = 4'h0;
    {delayed_warn_i, warn_code_i, mains_ok_i} = {16'h0000, 1'b1};
    // limit trip, warning follows the switch, then leave in the free direction
    vel_pos_req_i = 1'b1;
    wt(4);
    limit_pos_i = 1'b1;
    wt(4);
    chk(run_pos_o === 1'b0 && limit_error_o === 1'b1, "limit trip");
    rdc(`DCM_PAR_CTRL_STATUS, 16'h000A, 16'h000E);
    limit_pos_i = 1'b0;
    wt(4);
    chk(status_word_o[7] === 1'b0, "limit warning cleared");
    wr(`DCM_PAR_CTRL_WORD, 16'h0081, 1'b0);
    wr(`DCM_PAR_CTRL_WORD, 16'h0001, 1'b0);
    {vel_pos_req_i, vel_neg_req_i} = 2'b01;
    wt(4);
    chk(limit_error_o === 1'b0 && run_neg_o === 1'b1, "free direction");
    vel_neg_req_i = 1'b0;
    // relative move without homing, absolute request starts homing
    {rel_pos_req_i, target_dir_pos_i} = 2'b11;
    wt(4);
    chk(run_pos_o === 1'b1 && homed_o === 1'b0, "relative unhomed");
    rel_pos_req_i = 1'b0;
    wr(`DCM_PAR_HOMING_MODE, 16'h0001, 1'b0);
    abs_pos_req_i = 1'b1;
    wt(4);
    chk(abs_start_o === 1'b0 && run_pos_o === 1'b1, "auto homing search");
    home_switch_i = 1'b1;
    wt(4);
    // held at the switch; the pending absolute move then starts towards its target
    chk(run_pos_o === 1'b1 && homed_o === 1'b1 && goto_init_o === 1'b0, "hold");
    chk(abs_start_o === 1'b1, "absolute after homing");
    {abs_pos_req_i, home_switch_i} = 2'b00;
    // pin start, reverse at the limit, then move to the initial position
    wr(`DCM_PAR_FAULT_REACT, 16'h0000, 1'b0);
    wr(`DCM_PAR_HOMING_MODE, 16'h0003, 1'b0);
    wr(`DCM_PAR_INIT_POS, 16'h0010, 1'b0);
    home_start_in_i = 1'b1;
    wt(4);
    chk(homed_o === 1'b0 && run_pos_o === 1'b1, "pin homing start");
    {home_start_in_i, limit_pos_i} = 2'b01;
    wt(4);
    chk(run_neg_o === 1'b1 && run_pos_o === 1'b0, "reverse at limit");
    home_switch_i = 1'b1;
    wt(4);
    chk(goto_init_o === 1'b1 && homed_o === 1'b0, "move to initial");
    {limit_pos_i, home_switch_i, at_target_i} = 3'b001;
    wt(4);
    chk(homed_o === 1'b1 && goto_init_o === 1'b0, "initial reached");
    at_target_i = 1'b0;
    // control word start
    wr(`DCM_PAR_INIT_POS, 16'hFFFF, 1'b0);
    wr(`DCM_PAR_CTRL_WORD, 16'h2001, 1'b0);
    wr(`DCM_PAR_CTRL_WORD, 16'h0001, 1'b0);
    chk(homed_o === 1'b0, "bus homing start");
    home_switch_i = 1'b1;
    wt(4);
    chk(homed_o === 1'b1 && run_pos_o === 1'b0, "stop at home switch");
    end_of_test();
  end
endmodule // test_drive_control_mode_status
